// >>> imu_regs_pkg.sv
// shared constants and types for the inertial sensor rate and command registers
package imu_regs_pkg;
   // clock and serial frame
   localparam int CLK_HZ = 40_000_000;
   localparam int FRAME_BITS = 16;
   localparam int WRITE_BIT = 15;

   // register offsets, byte addresses of the low byte
   localparam logic [6:0] ADDR_SYNC_MULT = 7'h62;
   localparam logic [6:0] ADDR_DECIM = 7'h64;
   localparam logic [6:0] ADDR_CMD = 7'h68;
   localparam logic [6:0] ADDR_CODE_VER = 7'h6C;
   localparam logic [6:0] ADDR_BUILD_DM = 7'h6E;

   // reset values and field limits
   localparam logic [15:0] SYNC_MULT_RST = 16'h07D0;
   localparam logic [15:0] DECIM_RST = 16'h0000;
   localparam int DECIM_W = 11;
   localparam logic [10:0] DECIM_MAX = 11'h7CF;

   // command and diagnostic bit positions
   localparam int CMD_BIT_RESET = 7;
   localparam int CMD_BIT_FLASH_TEST = 4;
   localparam int CMD_BIT_BACKUP = 3;
   localparam int CMD_BIT_SELF_TEST = 2;
   localparam int CMD_BIT_RESTORE = 1;
   localparam int DIAG_CRC_BIT = 6;
   localparam int DIAG_SELF_TEST_BIT = 5;
   localparam int DIAG_BACKUP_BIT = 2;

   // timing
   localparam int DEC_SETTLE_US = 30;
   localparam int DEC_SETTLE_CYC = DEC_SETTLE_US * (CLK_HZ / 1_000_000);
   localparam int INT_RATE_HZ = 2000;
   localparam int INT_TICK_CYC = CLK_HZ / INT_RATE_HZ;
   localparam int EXEC_CYC_DEF = 1000;

   // read-only contents, values arbitrary
   localparam logic [15:0] CODE_VERSION_DEF = 16'h0100;
   localparam logic [15:0] BUILD_DM_DEF = 16'h0101;

   // sample path
   localparam int CHANS = 6;
   localparam int SAMPLE_W = 16;
   localparam int SUM_W = SAMPLE_W + DECIM_W;
   localparam int PERIOD_W = 26;

   typedef enum logic [1:0] {
      SYNC_INTERNAL = 2'b00,
      SYNC_DIRECT = 2'b01,
      SYNC_SCALED = 2'b10,
      SYNC_OUTPUT = 2'b11
   } sync_mode_e;

   typedef enum logic [1:0] {
      CMD_IDLE = 2'b01,
      CMD_EXEC = 2'b10
   } cmd_state_e;

   typedef logic [SAMPLE_W-1:0] chan_t;
   typedef logic [SUM_W-1:0] sum_t;
   typedef struct packed {chan_t [CHANS-1:0] ch;} sample_s;
   typedef struct packed {sum_t [CHANS-1:0] ch;} delta_s;
   typedef struct packed {
      logic reset;
      logic flash_test;
      logic flash_backup;
      logic self_test;
      logic restore;
   } cmd_ops_s;
   typedef struct packed {
      logic [15:0] sync_mult;
      logic [15:0] decim;
   } backup_s;
endpackage

// >>> sample_clock_gen.sv
// sample tick generator for internal, direct sync and scaled sync clocking
`timescale 1ns/1ps
module sample_clock_gen #(
   parameter int INT_CYC = imu_regs_pkg::INT_TICK_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic halt,
   input wire imu_regs_pkg::sync_mode_e mode,
   input wire logic [15:0] mult,
   input wire logic sync_i,
   output logic tick,
   output logic sync_o,
   output logic sync_oe
);
   import imu_regs_pkg::*;

   localparam int CNT_W = $clog2(INT_CYC);

   if (INT_CYC < 2) begin : g_bad_int
      $error("internal tick period must be at least two cycles");
   end

   logic [CNT_W-1:0] int_cnt_q;
   logic int_tick;
   logic sync_q;
   logic sync_rise;
   logic [PERIOD_W-1:0] per_cnt_q;
   logic [PERIOD_W-1:0] period_q;
   logic [PERIOD_W:0] acc_q;
   logic [PERIOD_W:0] sc_sum;
   logic sc_tick;

   // free running internal sample clock
   assign int_tick = int_cnt_q == CNT_W'(INT_CYC - 1);
   always_ff @(posedge clk) begin
      if (rst || int_tick) begin
         int_cnt_q <= '0;
      end else begin
         int_cnt_q <= int_cnt_q + 1'b1;
      end
   end

   // sync pin edge, only while the pin is an input
   assign sync_rise = mode != SYNC_OUTPUT && sync_i && !sync_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         sync_q <= 1'b0;
      end else begin
         sync_q <= sync_i;
      end
   end

   // sync period measured in clock cycles, saturating
   always_ff @(posedge clk) begin
      if (rst) begin
         per_cnt_q <= '0;
         period_q <= '0;
      end else if (sync_rise) begin
         period_q <= (per_cnt_q == '1) ? per_cnt_q : per_cnt_q + 1'b1;
         per_cnt_q <= '0;
      end else if (per_cnt_q != '1) begin
         per_cnt_q <= per_cnt_q + 1'b1;
      end
   end

   assign sc_sum = acc_q + (PERIOD_W + 1)'(mult);
   assign sc_tick = period_q != '0 && sc_sum >= {1'b0, period_q};
   always_ff @(posedge clk) begin
      if (rst || sync_rise || period_q == '0) begin
         acc_q <= '0;
      end else if (sc_tick) begin
         acc_q <= sc_sum - {1'b0, period_q};
      end else begin
         acc_q <= sc_sum;
      end
   end

   // mode decode; direct mode one tick per edge
   always_comb begin
      case (mode)
         SYNC_INTERNAL: tick = int_tick;
         SYNC_DIRECT: tick = sync_rise;
         SYNC_SCALED: tick = sc_tick;
         SYNC_OUTPUT: tick = int_tick;
         default: tick = int_tick;
      endcase
      if (halt) begin
         tick = 1'b0;
      end
   end

   // sample indicator on the sync pin in output mode
   assign sync_oe = mode == SYNC_OUTPUT;
   always_ff @(posedge clk) begin
      if (rst) begin
         sync_o <= 1'b0;
      end else begin
         sync_o <= mode == SYNC_OUTPUT && int_tick && !halt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   direct_tick_a: assert property (mode == SYNC_DIRECT && sync_rise && !halt |-> tick)
      else $error("direct sync edge gave no tick");
   output_mode_a: assert property (mode == SYNC_OUTPUT |-> sync_oe && !sync_rise)
      else $error("output sync mode not driving pin");
   halt_tick_a: assert property (halt |-> !tick)
      else $error("tick while halted");
   scaled_cov_c: cover property (mode == SYNC_SCALED && sc_tick);
endmodule

// >>> imu_rate_cmd_regs.sv
// serial register bank, command sequencer and decimating averager for the sensor
// Operation
// - multiplier defaults 0x07D0, readback after ready
// - decimation eleven bits, max 1999
// - decimation readback settles within 30 us
// - average and integrate over decimation window
// - internal rate 2000 over decimation plus one
// - scaled sync rate fsync times multiplier
// - direct sync treats multiplier as one
// - write-only command bits 7,4,3,2,1
// - writing one starts the operation
// - busy halts data, ready, serial port
// - software reset equals hardware reset
// - flash test mismatch sets diagnostic bit 6
// - backup outcome in diagnostic bit 2
// - self test result in diagnostic bit 5
// - restore returns decimation to its default; multiplier unchanged
// - read-only BCD code version
// - read-only BCD month and day
// - multiplier, decimation read/write, backed, defaulted
// - sync mode decode 00,01,10,11
`timescale 1ns/1ps
module imu_rate_cmd_regs #(
   parameter int INT_TICK_CYC = imu_regs_pkg::INT_TICK_CYC,
   parameter int RESET_CYC = imu_regs_pkg::EXEC_CYC_DEF,
   parameter int FLASH_TEST_CYC = imu_regs_pkg::EXEC_CYC_DEF,
   parameter int BACKUP_CYC = imu_regs_pkg::EXEC_CYC_DEF,
   parameter int SELF_TEST_CYC = imu_regs_pkg::EXEC_CYC_DEF,
   parameter int RESTORE_CYC = imu_regs_pkg::EXEC_CYC_DEF,
   parameter logic [15:0] CODE_VERSION = imu_regs_pkg::CODE_VERSION_DEF,
   parameter logic [15:0] BUILD_DAY_MONTH = imu_regs_pkg::BUILD_DM_DEF
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic spi_din,
   output logic spi_dout,
   input wire imu_regs_pkg::sync_mode_e sync_mode,
   input wire logic sync_i,
   output logic sync_o,
   output logic sync_oe,
   output logic sample_tick,
   input wire imu_regs_pkg::sample_s sample_i,
   output imu_regs_pkg::sample_s avg_o,
   output imu_regs_pkg::delta_s delta_o,
   output logic sample_ready,
   output imu_regs_pkg::cmd_ops_s op_start,
   output logic op_busy,
   input wire logic crc_match,
   input wire logic backup_ok,
   input wire logic self_test_ok,
   output logic [15:0] diag_flags,
   output imu_regs_pkg::backup_s backup_image,
   output logic soft_reset
);
   import imu_regs_pkg::*;

   localparam int SETTLE_W = $clog2(DEC_SETTLE_CYC + 1);
   localparam int TIMER_W = 24;

   if (RESET_CYC < 1 || FLASH_TEST_CYC < 1 || BACKUP_CYC < 1 || SELF_TEST_CYC < 1 || RESTORE_CYC < 1 ||
       RESET_CYC >= 2**TIMER_W || FLASH_TEST_CYC >= 2**TIMER_W || BACKUP_CYC >= 2**TIMER_W ||
       SELF_TEST_CYC >= 2**TIMER_W || RESTORE_CYC >= 2**TIMER_W) begin : g_bad_exec
      $error("command execution counts out of range");
   end
   // every nibble must be a decimal digit
   for (genvar n = 0; n < 4; n++) begin : g_bcd
      if (CODE_VERSION[4*n +: 4] > 4'h9 || BUILD_DAY_MONTH[4*n +: 4] > 4'h9) begin : g_bad_bcd
         $error("read-only date or version is not BCD");
      end
   end

   logic soft_rst_q;
   logic rst_all;
   logic busy;
   logic tick;
   cmd_state_e st_q;
   cmd_ops_s pend_q;
   cmd_ops_s cur_q;
   cmd_ops_s new_ops;
   logic [TIMER_W-1:0] timer_q;
   logic exec_done;
   logic restore_done;
   logic sclk_q;
   logic cs_n_q;
   logic [3:0] bit_cnt_q;
   logic [14:0] rx_sh_q;
   logic [15:0] tx_sh_q;
   logic [15:0] tx_word_q;
   logic [15:0] frame;
   logic [15:0] rd_data;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic frame_ok;
   logic wr_en;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic cmd_trig;
   logic dec_wr;
   logic [15:0] mult_pend_q;
   logic [15:0] mult_eff_q;
   logic [10:0] dec_pend_q;
   logic [10:0] dec_eff_q;
   logic [10:0] dec_clamp;
   logic [SETTLE_W-1:0] settle_cnt_q;
   logic [7:0] cmd_lo_q;
   logic [15:0] diag_q;
   logic [10:0] cnt_q;
   logic dec_strobe;
   logic [SUM_W-1:0] acc_q [CHANS];
   logic [SUM_W-1:0] tot [CHANS];
   logic [SUM_W-1:0] num_q [CHANS];
   logic [12:0] rem_q [CHANS];
   logic [12:0] rem_n [CHANS];
   logic [CHANS-1:0] fit;
   logic [CHANS-1:0] neg_q;
   logic [4:0] div_cnt_q;
   logic div_run_q;
   logic fin_q;
   logic [12:0] divisor_q;

   function automatic cmd_ops_s pick_op(input cmd_ops_s p);
      cmd_ops_s r;
      r = '0;
      if (p.reset) r.reset = 1'b1;
      else if (p.flash_test) r.flash_test = 1'b1;
      else if (p.flash_backup) r.flash_backup = 1'b1;
      else if (p.self_test) r.self_test = 1'b1;
      else if (p.restore) r.restore = 1'b1;
      return r;
   endfunction

   function automatic logic [TIMER_W-1:0] exec_cyc(input cmd_ops_s op);
      if (op.reset) return TIMER_W'(RESET_CYC);
      if (op.flash_test) return TIMER_W'(FLASH_TEST_CYC);
      if (op.flash_backup) return TIMER_W'(BACKUP_CYC);
      if (op.self_test) return TIMER_W'(SELF_TEST_CYC);
      return TIMER_W'(RESTORE_CYC);
   endfunction

   // software reset acts like the reset pin
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         soft_rst_q <= 1'b0;
      end else begin
         soft_rst_q <= exec_done && cur_q.reset;
      end
   end
   assign rst_all = sys_rst || soft_rst_q;
   assign soft_reset = soft_rst_q;
   assign busy = st_q != CMD_IDLE || pend_q != '0;
   assign op_busy = busy;

   // serial frame edges, pins taken as synchronous
   assign sclk_rise = spi_sclk && !sclk_q && !spi_cs_n;
   assign sclk_fall = !spi_sclk && sclk_q && !spi_cs_n;
   assign cs_fall = cs_n_q && !spi_cs_n;
   assign frame = {rx_sh_q, spi_din};
   // frames dropped while a command runs
   assign frame_ok = sclk_rise && bit_cnt_q == 4'hF && !busy;
   assign wr_en = frame_ok && frame[WRITE_BIT];
   assign addr = frame[14:8];
   assign wdata = frame[7:0];
   // high byte write fires the latched bits
   assign cmd_trig = wr_en && addr[6:1] == ADDR_CMD[6:1] && addr[0];
   assign dec_wr = wr_en && addr[6:1] == ADDR_DECIM[6:1];
   assign spi_dout = tx_sh_q[15];

   // shift registers, mode 3 timing
   always_ff @(posedge clk) begin
      if (rst_all) begin
         sclk_q <= 1'b1;
         cs_n_q <= 1'b1;
         bit_cnt_q <= '0;
         rx_sh_q <= '0;
         tx_sh_q <= '0;
      end else begin
         sclk_q <= spi_sclk;
         cs_n_q <= spi_cs_n;
         if (cs_fall) begin
            bit_cnt_q <= '0;
            tx_sh_q <= busy ? 16'h0000 : tx_word_q;
         end else begin
            if (sclk_rise) begin
               rx_sh_q <= frame[14:0];
               bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            if (sclk_fall && bit_cnt_q != 4'h0) begin
               tx_sh_q <= {tx_sh_q[14:0], 1'b0};
            end
         end
      end
   end

   // readback mux; command reads as zero
   always_comb begin
      case ({addr[6:1], 1'b0})
         ADDR_SYNC_MULT: rd_data = mult_eff_q;
         ADDR_DECIM: rd_data = {5'h00, dec_eff_q};
         ADDR_CODE_VER: rd_data = CODE_VERSION;
         ADDR_BUILD_DM: rd_data = BUILD_DAY_MONTH;
         default: rd_data = 16'h0000;
      endcase
   end

   // read request answered in the next frame
   always_ff @(posedge clk) begin
      if (rst_all) begin
         tx_word_q <= '0;
      end else if (frame_ok && !frame[WRITE_BIT]) begin
         tx_word_q <= rd_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst_all) begin
         mult_pend_q <= SYNC_MULT_RST;
         mult_eff_q <= SYNC_MULT_RST;
      end else begin
         if (wr_en && addr[6:1] == ADDR_SYNC_MULT[6:1] && !addr[0]) mult_pend_q[7:0] <= wdata;
         if (wr_en && addr[6:1] == ADDR_SYNC_MULT[6:1] && addr[0]) mult_pend_q[15:8] <= wdata;
         if (sample_ready) mult_eff_q <= mult_pend_q;
      end
   end

   // clamp to the largest legal setting
   assign dec_clamp = (dec_pend_q > DECIM_MAX) ? DECIM_MAX : dec_pend_q;

   always_ff @(posedge clk) begin
      if (rst_all || restore_done) begin
         dec_pend_q <= DECIM_RST[10:0];
         dec_eff_q <= DECIM_RST[10:0];
         settle_cnt_q <= '0;
      end else if (dec_wr) begin
         if (addr[0]) dec_pend_q[10:8] <= wdata[2:0];
         else dec_pend_q[7:0] <= wdata;
         settle_cnt_q <= SETTLE_W'(DEC_SETTLE_CYC);
      end else if (settle_cnt_q != '0) begin
         settle_cnt_q <= settle_cnt_q - 1'b1;
         if (settle_cnt_q == SETTLE_W'(1)) dec_eff_q <= dec_clamp;
      end
   end
   assign backup_image = '{sync_mult: mult_pend_q, decim: {5'h00, dec_eff_q}};

   always_comb begin
      new_ops.reset = cmd_lo_q[CMD_BIT_RESET];
      new_ops.flash_test = cmd_lo_q[CMD_BIT_FLASH_TEST];
      new_ops.flash_backup = cmd_lo_q[CMD_BIT_BACKUP];
      new_ops.self_test = cmd_lo_q[CMD_BIT_SELF_TEST];
      new_ops.restore = cmd_lo_q[CMD_BIT_RESTORE];
   end
   assign exec_done = st_q == CMD_EXEC && timer_q == TIMER_W'(1);
   assign restore_done = exec_done && cur_q.restore;

   // command sequencer, one operation at a time
   always_ff @(posedge clk) begin
      if (rst_all) begin
         st_q <= CMD_IDLE;
         pend_q <= '0;
         cur_q <= '0;
         op_start <= '0;
         timer_q <= '0;
         cmd_lo_q <= '0;
      end else begin
         op_start <= '0;
         if (wr_en && addr == ADDR_CMD) cmd_lo_q <= wdata;
         if (cmd_trig) begin
            pend_q <= new_ops;
            cmd_lo_q <= '0;
         end
         case (st_q)
            CMD_IDLE: begin
               if (pend_q != '0) begin
                  cur_q <= pick_op(pend_q);
                  op_start <= pick_op(pend_q);
                  pend_q <= cmd_ops_s'(pend_q & ~pick_op(pend_q));
                  timer_q <= exec_cyc(pick_op(pend_q));
                  st_q <= CMD_EXEC;
               end
            end
            CMD_EXEC: begin
               if (exec_done) st_q <= CMD_IDLE;
               else timer_q <= timer_q - 1'b1;
            end
            default: st_q <= CMD_IDLE;
         endcase
      end
   end

   // outcome of flash and sensor tests
   always_ff @(posedge clk) begin
      if (rst_all) begin
         diag_q <= '0;
      end else if (exec_done) begin
         if (cur_q.flash_test) diag_q[DIAG_CRC_BIT] <= !crc_match;
         if (cur_q.flash_backup) diag_q[DIAG_BACKUP_BIT] <= !backup_ok;
         if (cur_q.self_test) diag_q[DIAG_SELF_TEST_BIT] <= !self_test_ok;
      end
   end
   assign diag_flags = diag_q;

   sample_clock_gen #(.INT_CYC(INT_TICK_CYC)) u_clock (
      .clk(clk),
      .rst(rst_all),
      .halt(busy),
      .mode(sync_mode),
      .mult(mult_eff_q),
      .sync_i(sync_i),
      .tick(tick),
      .sync_o(sync_o),
      .sync_oe(sync_oe)
   );
   assign sample_tick = tick;

   // window sums and divider step
   always_comb begin
      for (int i = 0; i < CHANS; i++) begin
         tot[i] = acc_q[i] + SUM_W'($signed(sample_i.ch[i]));
         rem_n[i] = {rem_q[i][11:0], num_q[i][SUM_W-1]};
         fit[i] = rem_n[i] >= divisor_q;
      end
   end
   // one output per decimation setting plus one ticks
   assign dec_strobe = tick && cnt_q >= dec_eff_q;

   // accumulate, then divide by the window length
   always_ff @(posedge clk) begin
      if (rst_all) begin
         for (int i = 0; i < CHANS; i++) begin
            acc_q[i] <= '0;
            num_q[i] <= '0;
            rem_q[i] <= '0;
         end
         cnt_q <= '0;
         neg_q <= '0;
         div_cnt_q <= '0;
         div_run_q <= 1'b0;
         divisor_q <= 13'h0001;
         delta_o <= '0;
      end else begin
         if (tick) begin
            cnt_q <= dec_strobe ? 11'h000 : cnt_q + 11'h001;
            for (int i = 0; i < CHANS; i++) acc_q[i] <= dec_strobe ? '0 : tot[i];
         end
         if (dec_strobe) begin
            for (int i = 0; i < CHANS; i++) begin
               delta_o.ch[i] <= tot[i];
               num_q[i] <= tot[i][SUM_W-1] ? SUM_W'(-tot[i]) : tot[i];
               neg_q[i] <= tot[i][SUM_W-1];
               rem_q[i] <= '0;
            end
            divisor_q <= {2'b00, dec_eff_q} + 13'h0001;
            div_cnt_q <= 5'(SUM_W);
            div_run_q <= 1'b1;
         end else if (div_run_q) begin
            for (int i = 0; i < CHANS; i++) begin
               rem_q[i] <= fit[i] ? rem_n[i] - divisor_q : rem_n[i];
               num_q[i] <= {num_q[i][SUM_W-2:0], fit[i]};
            end
            div_cnt_q <= div_cnt_q - 5'h01;
            if (div_cnt_q == 5'h01) div_run_q <= 1'b0;
         end
      end
   end

   // averaged sample and ready pulse, no ready pulse while busy
   always_ff @(posedge clk) begin
      if (rst_all) begin
         fin_q <= 1'b0;
         sample_ready <= 1'b0;
         avg_o <= '0;
      end else begin
         fin_q <= div_run_q && div_cnt_q == 5'h01 && !dec_strobe;
         sample_ready <= fin_q && !busy;
         if (fin_q) begin
            for (int i = 0; i < CHANS; i++) avg_o.ch[i] <= neg_q[i] ? -num_q[i][15:0] : num_q[i][15:0];
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst_all);

   busy_no_write_a: assert property (busy |=> $stable(mult_pend_q))
      else $error("register written while command busy");
   busy_no_ready_a: assert property ($past(busy) |-> !sample_ready)
      else $error("ready pulse while command busy");
   dec_clamp_a: assert property (dec_eff_q <= DECIM_MAX)
      else $error("decimation above legal maximum");
   dec_upper_a: assert property (frame_ok && !frame[WRITE_BIT] && {addr[6:1], 1'b0} == ADDR_DECIM
      |=> tx_word_q[15:11] == 5'h00)
      else $error("decimation upper bits not zero");
   dec_load_a: assert property (dec_wr |=> settle_cnt_q == SETTLE_W'(DEC_SETTLE_CYC))
      else $error("settle timer not loaded on write");
   dec_settle_a: assert property (settle_cnt_q != '0 && !dec_wr && !restore_done
      |=> settle_cnt_q == $past(settle_cnt_q) - 1'b1)
      else $error("settle timer not counting down");
   dec_apply_a: assert property (settle_cnt_q == SETTLE_W'(1) && !dec_wr && !restore_done
      |=> dec_eff_q == $past(dec_clamp))
      else $error("settled decimation not applied");
   cmd_start_a: assert property (cmd_trig && new_ops != '0 |=> busy ##1 op_start != '0)
      else $error("command write did not start operation");
   restore_dec_a: assert property (restore_done |=> dec_eff_q == DECIM_RST[10:0] && !busy)
      else $error("restore left decimation changed");
   crc_flag_a: assert property (exec_done && cur_q.flash_test && !crc_match |=> diag_q[DIAG_CRC_BIT])
      else $error("crc mismatch not flagged");
   backup_flag_a: assert property (exec_done && cur_q.flash_backup |=> diag_q[DIAG_BACKUP_BIT] == !$past(backup_ok))
      else $error("backup outcome not reported");
   soft_reset_a: assert property (disable iff (sys_rst) exec_done && cur_q.reset
      |=> soft_rst_q ##1 mult_eff_q == SYNC_MULT_RST && st_q == CMD_IDLE)
      else $error("software reset did not restore defaults");
   avg_latency_a: assert property (dec_strobe |-> ##29 (sample_ready || $past(busy)))
      else $error("averaged sample late or missing");
   mult_apply_a: assert property (sample_ready |=> mult_eff_q == $past(mult_pend_q))
      else $error("multiplier readback not updated on ready");

   reset_cmd_c: cover property (exec_done && cur_q.reset);
   restore_cmd_c: cover property (restore_done);
   ready_seen_c: cover property (sample_ready && dec_eff_q != 11'h000);
   read_frame_c: cover property (frame_ok && !frame[WRITE_BIT]);
endmodule

// >>> spi_host_model.sv
// serial host model sending 16-bit frames, clock idle high
`timescale 1ns/1ps
module spi_host_model (
   input wire logic clk,
   input wire logic dout,
   output logic cs_n,
   output logic sclk,
   output logic din
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b1;
      din = 1'b0;
   end
   // one frame, msb first; data set in low phase, reply read on rise
   task automatic xfer(input logic [15:0] f, output logic [15:0] r);
      @(negedge clk);
      cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         @(negedge clk);
         sclk = 1'b0;
         din = f[i];
         repeat (2) @(negedge clk);
         sclk = 1'b1;
         r[i] = dout;
         repeat (2) @(negedge clk);
      end
      @(negedge clk);
      cs_n = 1'b1;
      // released line shows the inverse of the last bit
      din = ~din;
      repeat (2) @(negedge clk);
   endtask
endmodule

// >>> imu_rate_cmd_regs_tb.sv
// self-checking bench for the rate and command register bank
`timescale 1ns/1ps
module imu_rate_cmd_regs_tb;
   import imu_regs_pkg::*;
   logic clk = 1'b0, sys_rst = 1'b1, crc_match = 1'b1, backup_ok = 1'b1, self_test_ok = 1'b1;
   logic cs_n, sclk, din, dout, so, soe, tick, ready, busy, srst;
   sample_s smp = '0;
   cmd_ops_s op_start, ops_seen;
   logic [15:0] diag, rd, ed = '0;
   int fail_count = 0, checked = 0, ready_busy = 0;
   int ticks = 0, so_cnt = 0, srst_cnt = 0;
   sync_mode_e mode = SYNC_INTERNAL;
   logic sync_in = 1'b0;
   logic [6:0] adr [6] = '{ADDR_SYNC_MULT, ADDR_DECIM, ADDR_CMD, ADDR_CODE_VER, ADDR_BUILD_DM, 7'h40};
   logic [15:0] rst_v [6] = '{SYNC_MULT_RST, DECIM_RST, 16'h0000, CODE_VERSION_DEF, BUILD_DM_DEF, 16'h0000};
   int cb [3] = '{CMD_BIT_FLASH_TEST, CMD_BIT_BACKUP, CMD_BIT_SELF_TEST};
   always #12.5 clk = ~clk;
   spi_host_model i_spi_host_model (.clk(clk), .dout(dout), .cs_n(cs_n), .sclk(sclk), .din(din));
   imu_rate_cmd_regs #(.INT_TICK_CYC(40), .RESET_CYC(5), .FLASH_TEST_CYC(5), .BACKUP_CYC(5), .SELF_TEST_CYC(5),
      .RESTORE_CYC(5)) i_imu_rate_cmd_regs (.clk(clk), .sys_rst(sys_rst), .spi_cs_n(cs_n), .spi_sclk(sclk),
      .spi_din(din), .spi_dout(dout), .sync_mode(mode), .sync_i(sync_in), .sync_o(so), .sync_oe(soe),
      .sample_tick(tick), .sample_i(smp), .avg_o(), .delta_o(), .sample_ready(ready), .op_start(op_start),
      .op_busy(busy), .crc_match(crc_match), .backup_ok(backup_ok), .self_test_ok(self_test_ok),
      .diag_flags(diag), .backup_image(), .soft_reset(srst));
   // random sensor samples
   always @(negedge clk) smp <= {$urandom, $urandom, $urandom};
   // collect op pulses and ready pulses seen while busy
   always @(posedge clk) begin
      ops_seen <= ops_seen | op_start;
      if (busy && ready) ready_busy <= ready_busy + 1;
      if (tick) ticks <= ticks + 1;
      if (so) so_cnt <= so_cnt + 1;
      if (srst) srst_cnt <= srst_cnt + 1;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic results;
      if (fail_count == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic wr(input logic [6:0] a, input logic [15:0] v);
      i_spi_host_model.xfer({1'b1, a, v[7:0]}, rd);
      i_spi_host_model.xfer({1'b1, a + 7'h01, v[15:8]}, rd);
   endtask
   task automatic rdreg(input logic [6:0] a);
      i_spi_host_model.xfer({1'b0, a, 8'h00}, rd);
      i_spi_host_model.xfer(16'h0000, rd);
   endtask
   // fire one command and wait out its execution
   task automatic cmd(input int b);
      int n;
      ops_seen = '0;
      wr(ADDR_CMD, 16'(1 << b));
      n = 0;
      while (busy !== 1'b0 && n < 500) begin
         @(negedge clk);
         n++;
      end
      if (n == 500) begin
         fail_count++;
         results();
      end
      repeat (4) @(negedge clk);
   endtask
   // time between two ready pulses after a decimation change
   task automatic rate(input int d);
      int n;
      wr(ADDR_DECIM, 16'(d));
      repeat (1300) @(negedge clk);
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(negedge clk);
            n++;
         end while (ready !== 1'b1 && n < 2000);
      end
      chk(16'(n), 16'(40 * (d + 1)));
      if (n >= 2000) results();
   endtask
   // sync pin pulses, p cycles apart
   task automatic pulse(input int cnt, input int p);
      repeat (cnt) begin
         sync_in = 1'b1;
         repeat (5) @(negedge clk);
         sync_in = 1'b0;
         repeat (p - 5) @(negedge clk);
      end
   endtask
   initial begin
      void'($urandom(87848));
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
      foreach (adr[i]) begin
         rdreg(adr[i]);
         chk(rd, rst_v[i]);
      end
      wr(ADDR_CODE_VER, 16'($urandom));
      rdreg(ADDR_CODE_VER);
      chk(rd, CODE_VERSION_DEF);
      wr(ADDR_DECIM, 16'hFFFF);
      repeat (1250) @(negedge clk);
      rdreg(ADDR_DECIM);
      chk(rd, 16'h07CF);
      rate(0);
      rate(1);
      rate(2 + $urandom % 3);
      wr(ADDR_SYNC_MULT, 16'h1234);
      repeat (200) @(negedge clk);
      rdreg(ADDR_SYNC_MULT);
      chk(rd, 16'h1234);
      wr(ADDR_SYNC_MULT, 16'h0004);
      // direct sync, one tick per edge
      mode = SYNC_DIRECT;
      ticks = 0;
      pulse(10, 50);
      chk(16'(ticks), 16'h000A);
      chk(16'(soe), 16'h0000);
      // scaled sync, four ticks per period
      mode = SYNC_SCALED;
      pulse(1, 200);
      sync_in = 1'b1;
      @(negedge clk);
      ticks = 0;
      repeat (4) @(negedge clk);
      sync_in = 1'b0;
      repeat (195) @(negedge clk);
      pulse(3, 200);
      sync_in = 1'b1;
      @(negedge clk);
      chk(16'(ticks), 16'h0010);
      // output sync, pin shows sample ticks
      mode = SYNC_OUTPUT;
      sync_in = 1'b0;
      @(negedge clk);
      so_cnt = 0;
      repeat (400) @(negedge clk);
      chk(16'(so_cnt), 16'h000A);
      chk(16'(soe), 16'h0001);
      mode = SYNC_INTERNAL;
      foreach (cb[i]) begin
         {crc_match, backup_ok, self_test_ok} = 3'($urandom);
         cmd(cb[i]);
         ed[i == 0 ? DIAG_CRC_BIT : i == 1 ? DIAG_BACKUP_BIT : DIAG_SELF_TEST_BIT] =
            ~(i == 0 ? crc_match : i == 1 ? backup_ok : self_test_ok);
         chk(16'(ops_seen), 16'(5'(1 << (cb[i] - 1))));
         chk(diag, ed);
      end
      wr(ADDR_DECIM, 16'h0005);
      repeat (1250) @(negedge clk);
      cmd(CMD_BIT_RESTORE);
      rdreg(ADDR_DECIM);
      chk(rd, DECIM_RST);
      cmd(CMD_BIT_RESET);
      chk(16'(ops_seen), 16'h0010);
      chk(16'(srst_cnt), 16'h0001);
      chk(diag, 16'h0000);
      rdreg(ADDR_SYNC_MULT);
      chk(rd, SYNC_MULT_RST);
      chk(16'(ready_busy), 16'h0000);
      results();
   end
endmodule
